/* axis_route_pkg.sv */
package axis_route_pkg;

  // ****************************************************
  // Geometry
  // ****************************************************
  localparam int AXES         = 4;
  localparam int OUTS         = 8;
  localparam int DIR_OFFSET   = 4;
  localparam int AXES_PER_ADP = 2;
  localparam int ADAPTERS     = AXES / AXES_PER_ADP;
  localparam int SEL_W        = $clog2(OUTS);

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_HZ       = 40_000_000;
  localparam int MAIN_MAX_HZ  = 100_000;
  // Least pulse spacing on main transistor outputs, rounded up
  localparam int MIN_GAP_CYC  = (CLK_HZ + MAIN_MAX_HZ - 1) / MAIN_MAX_HZ;
  localparam int GAP_W        = $clog2(MIN_GAP_CYC + 1);

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic {MODE_FP_RP, MODE_PLS_DIR} out_mode_t;

  typedef enum logic [1:0] {LANE_IDLE, LANE_MAIN, LANE_ADP, LANE_RELAY} lane_st_t;

  typedef struct packed {
    logic active;
    logic pulse;
    logic fwd;
  } axis_cmd_t;

  typedef struct packed {
    logic             req;
    logic             remap;
    logic [SEL_W-1:0] sel;
  } clear_cmd_t;

  typedef struct packed {
    logic pulse;
    logic pair;
  } adp_pins_t;

  typedef struct packed {
    lane_st_t         st;
    logic             single_pulse_train;
    logic             pair;
    logic             drv_p;
    logic             drv_d;
    logic             prev;
    logic             seen;
    logic [GAP_W-1:0] gap;
    logic             over;
  } lane_state_t;

  typedef struct packed {
    logic [OUTS-1:0]             main;
    adp_pins_t [AXES-1:0]        adp;
    logic [AXES-1:0]             blk;
  } top_state_t;

  localparam logic [GAP_W-1:0] GAP_ZERO = '0;
  localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(MIN_GAP_CYC - 1);
  localparam logic [GAP_W-1:0] GAP_MAX  = '1;

endpackage : axis_route_pkg

/* axis_lane.sv */
`timescale 1ns/1ps
module axis_lane (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire axis_route_pkg::axis_cmd_t cmd,
  input  wire axis_route_pkg::out_mode_t mode,
  input  wire logic                   on_adp,
  input  wire logic                   relay_main,
  output logic                        img_pulse,
  output logic                        img_pair,
  output logic                        drv_pulse,
  output logic                        drv_pair,
  output logic                        overspeed
);
  import axis_route_pkg::*;

  lane_state_t q;
  lane_state_t d;
  logic        rise;

  always_comb begin
    d     = q;
    rise  = cmd.pulse & ~q.prev;
    d.prev = cmd.pulse;
    case (q.st)
      LANE_IDLE: begin
        if (cmd.active) begin
          if (relay_main) d.st = LANE_RELAY;
          else if (on_adp) d.st = LANE_ADP;
          else d.st = LANE_MAIN;
        end
      end
      default: begin
        if (!cmd.active) d.st = LANE_IDLE;
      end
    endcase
    d.single_pulse_train   = 1'b0;
    d.pair  = 1'b0;
    d.drv_p = 1'b0;
    d.drv_d = 1'b0;
    case (d.st)
      LANE_MAIN: begin
        d.drv_p = 1'b1;
        d.drv_d = 1'b1;
        d.single_pulse_train   = cmd.pulse;
        d.pair  = cmd.fwd;
      end
      LANE_ADP: begin
        d.drv_p = 1'b1;
        d.drv_d = 1'b1;
        if (mode == MODE_FP_RP) begin
          d.single_pulse_train  = cmd.pulse & cmd.fwd;
          d.pair = cmd.pulse & ~cmd.fwd;
        end else begin
          d.single_pulse_train  = cmd.pulse;
          d.pair = cmd.fwd;
        end
      end
      LANE_RELAY: begin
        // Relay contacts cannot chop pulses; output simply held on
        d.drv_p = 1'b1;
        d.single_pulse_train   = 1'b1;
        d.drv_d = 1'b1;
        d.pair  = cmd.fwd;
      end
      default: ;
    endcase
    // Spacing watch on transistor outputs in LANE_MAIN only, not LANE_ADP; sticky until reset
    if (d.st == LANE_MAIN) begin
      if (rise) begin
        if (q.seen && q.gap < GAP_LAST) d.over = 1'b1;
        d.gap  = GAP_ZERO;
        d.seen = 1'b1;
      end else if (q.gap != GAP_MAX) begin
        d.gap = q.gap + 1'b1;
      end
    end else begin
      d.gap  = GAP_ZERO;
      d.seen = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '{st: LANE_IDLE, gap: GAP_ZERO, default: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign img_pulse = q.single_pulse_train;
  assign img_pair  = q.pair;
  assign drv_pulse = q.drv_p;
  assign drv_pair  = q.drv_d;
  assign overspeed = q.over;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_relay_hold_on: assert property (
    cmd.active && relay_main && q.st == LANE_IDLE |=> ##[0:1] (img_pulse && drv_pulse)
  ) else $error("relay lane did not hold output on");

  a_fwd_rev_split: assert property (
    q.st == LANE_ADP && cmd.active && mode == MODE_FP_RP |=> !(img_pulse && img_pair)
  ) else $error("forward and reverse trains both high");

  a_dir_level: assert property (
    q.st == LANE_ADP && cmd.active && mode == MODE_PLS_DIR |=> img_pair == $past(cmd.fwd)
  ) else $error("direction level does not follow command");

  a_release_idle: assert property (
    !cmd.active |=> !drv_pulse && !drv_pair
  ) else $error("lane still owns outputs after release");

endmodule : axis_lane

/* pulse_output_axis_routing.sv */
`timescale 1ns/1ps
module pulse_output_axis_routing (
  input  wire logic                                              ref_clk,
  input  wire logic                                              rst,
  input  wire axis_route_pkg::axis_cmd_t  [axis_route_pkg::AXES-1:0]     axis_cmd,
  input  wire axis_route_pkg::clear_cmd_t [axis_route_pkg::AXES-1:0]     clear_cmd,
  input  wire logic [axis_route_pkg::OUTS-1:0]                   gp_out,
  input  wire logic [axis_route_pkg::ADAPTERS-1:0]               adapter_present,
  input  wire axis_route_pkg::out_mode_t  [axis_route_pkg::ADAPTERS-1:0] adapter_mode,
  input  wire logic                                              relay_main,
  output logic [axis_route_pkg::OUTS-1:0]                        main_out,
  output logic [axis_route_pkg::OUTS-1:0]                        main_led,
  output axis_route_pkg::adp_pins_t [axis_route_pkg::AXES-1:0]   adp_pins,
  output logic [axis_route_pkg::AXES-1:0]                        clear_blocked,
  output logic [axis_route_pkg::AXES-1:0]                        overspeed
);
  import axis_route_pkg::*;

  // ****************************************************
  // Per-axis lanes
  // ****************************************************
  logic [AXES-1:0] on_adp;
  logic [AXES-1:0] l_pls;
  logic [AXES-1:0] l_pair;
  logic [AXES-1:0] l_drv_p;
  logic [AXES-1:0] l_drv_d;

  for (genvar i = 0; i < AXES; i++) begin : g_lane
    // Axes pair onto adapters in order, two per adapter
    assign on_adp[i] = adapter_present[i / AXES_PER_ADP];
    axis_lane u_lane (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .cmd        (axis_cmd[i]),
      .mode       (adapter_mode[i / AXES_PER_ADP]),
      .on_adp     (on_adp[i]),
      .relay_main (relay_main),
      .img_pulse  (l_pls[i]),
      .img_pair   (l_pair[i]),
      .drv_pulse  (l_drv_p[i]),
      .drv_pair   (l_drv_d[i]),
      .overspeed  (overspeed[i])
    );
  end

  // ****************************************************
  // Output image
  // ****************************************************
  top_state_t       q;
  top_state_t       d;
  logic [OUTS-1:0]  img;
  logic [OUTS-1:0]  owned;
  logic [SEL_W-1:0] csel;

  always_comb begin
    d     = q;
    img   = gp_out;
    owned = '0;
    csel  = '0;
    for (int i = 0; i < AXES; i++) begin
      if (l_drv_p[i]) begin
        img[i]   = l_pls[i];
        owned[i] = 1'b1;
      end
      // Direction output is fixed; reserved whenever the adapter is fitted
      if (l_drv_d[i] || on_adp[i]) begin
        img[i + DIR_OFFSET]   = l_pair[i];
        owned[i + DIR_OFFSET] = 1'b1;
      end
    end
    for (int i = 0; i < AXES; i++) begin
      d.blk[i] = 1'b0;
      if (clear_cmd[i].remap) csel = clear_cmd[i].sel;
      else csel = SEL_W'(i + DIR_OFFSET);
      if (clear_cmd[i].req) begin
        // A clear never overrides a live pulse or reserved direction bit
        if (owned[csel]) d.blk[i] = 1'b1;
        else img[csel] = 1'b1;
      end
    end
    d.main = img;
    for (int i = 0; i < AXES; i++) begin
      if (on_adp[i]) begin
        d.adp[i].pulse = img[i];
        d.adp[i].pair  = img[i + DIR_OFFSET];
      end else begin
        d.adp[i] = '0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign main_out      = q.main;
  assign main_led      = q.main;
  assign adp_pins      = q.adp;
  assign clear_blocked = q.blk;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_dir_driven(int k);
    l_drv_d[k] && adapter_present[k / AXES_PER_ADP];
  endsequence

  a_dir_pairing: assert property (
    s_dir_driven(0) |=> main_out[DIR_OFFSET] == $past(l_pair[0]) && adp_pins[0].pair == main_out[DIR_OFFSET]
  ) else $error("axis one direction not on its paired output");

  a_second_adp_map: assert property (
    !adapter_present[1] [*2] |-> adp_pins[2] == '0 && adp_pins[3] == '0
  ) else $error("absent second adapter shows activity");

  a_first_adp_map: assert property (
    adapter_present[0] && l_drv_p[1] |=> adp_pins[1].pulse == $past(l_pls[1])
  ) else $error("axis two pulse not on first adapter");

  a_clear_collide: assert property (
    clear_cmd[0].req && !clear_cmd[0].remap && adapter_present[0] |=> clear_blocked[0]
  ) else $error("default clear did not yield to direction");

  a_gp_passthru: assert property (
    !l_drv_p[0] && clear_cmd == '0 |=> main_out[0] == $past(gp_out[0])
  ) else $error("free output does not follow ordinary control");

endmodule : pulse_output_axis_routing

/* servo_cmd_model.sv */
`timescale 1ns/1ps
// ****************************************************
// Drive-side command input: flags pulses spaced closer
// than the drive can accept
// ****************************************************
module servo_cmd_model #(
  parameter int MIN_IN_GAP = 4
) (
  input  wire logic                                            ref_clk,
  input  wire logic                                            rst,
  input  wire axis_route_pkg::adp_pins_t [axis_route_pkg::AXES-1:0] adp_pins,
  output logic [axis_route_pkg::AXES-1:0]                      too_fast
);
  import axis_route_pkg::*;

  logic [AXES-1:0] prev_q;
  int              gap_q [AXES];

  // Saturating gap count; a real drive just loses edges when overdriven
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < AXES; i++) begin
      if (rst) begin
        prev_q[i]   <= 1'b0;
        gap_q[i]    <= 1000;
        too_fast[i] <= 1'b0;
      end else begin
        prev_q[i] <= adp_pins[i].pulse;
        if (adp_pins[i].pulse && !prev_q[i]) begin
          if (gap_q[i] < MIN_IN_GAP) begin
            too_fast[i] <= 1'b1;
          end
          gap_q[i] <= 0;
        end else if (gap_q[i] < 1000) begin
          gap_q[i] <= gap_q[i] + 1;
        end
      end
    end
  end
endmodule : servo_cmd_model

/* pulse_output_axis_routing_tb.sv */
`timescale 1ns/1ps
module pulse_output_axis_routing_tb;
  import axis_route_pkg::*;

  logic                     ref_clk;
  logic                     rst;
  axis_cmd_t  [AXES-1:0]    axis_cmd;
  clear_cmd_t [AXES-1:0]    clear_cmd;
  logic [OUTS-1:0]          gp_out;
  logic [ADAPTERS-1:0]      adapter_present;
  out_mode_t [ADAPTERS-1:0] adapter_mode;
  logic                     relay_main;
  logic [OUTS-1:0]          main_out;
  logic [OUTS-1:0]          main_led;
  adp_pins_t [AXES-1:0]     adp_pins;
  logic [AXES-1:0]          clear_blocked;
  logic [AXES-1:0]          overspeed;
  logic [AXES-1:0]          too_fast;
  int                       n_errors;
  int                       cmp_count;

  pulse_output_axis_routing u_dut (
    .ref_clk(ref_clk), .rst(rst), .axis_cmd(axis_cmd), .clear_cmd(clear_cmd),
    .gp_out(gp_out), .adapter_present(adapter_present), .adapter_mode(adapter_mode),
    .relay_main(relay_main), .main_out(main_out), .main_led(main_led),
    .adp_pins(adp_pins), .clear_blocked(clear_blocked), .overspeed(overspeed));

  servo_cmd_model #(.MIN_IN_GAP(2)) u_drive (
    .ref_clk(ref_clk), .rst(rst), .adp_pins(adp_pins), .too_fast(too_fast));

  always #12.5 ref_clk = ~ref_clk;

  // ****************************************************
  // Helpers
  // ****************************************************
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Lane outputs need two edges; one spare edge for margin
  task settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle

  task step;
    @(posedge ref_clk);
    #1;
  endtask : step

  task go_idle;
    axis_cmd        = '0;
    clear_cmd       = '0;
    gp_out          = '0;
    relay_main      = 1'b0;
    adapter_present = '0;
    adapter_mode    = {MODE_FP_RP, MODE_FP_RP};
    settle;
  endtask : go_idle

  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // ****************************************************
  // Scenarios
  // ****************************************************
  task test_plain_outputs;
    gp_out = 8'ha5;
    settle;
    chk("main_out", 8'ha5, main_out);
    chk("main_led", 8'ha5, main_led);
    go_idle;
    $display("test plain_outputs done");
  endtask : test_plain_outputs

  task test_adapter_formats;
    adapter_present = 2'h3;
    axis_cmd[2]     = '{active: 1'b1, pulse: 1'b1, fwd: 1'b0};
    settle;
    chk("adp2 reverse", 8'h01, {6'h00, adp_pins[2]});
    chk("adp0 idle", 8'h00, {6'h00, adp_pins[0]});
    axis_cmd[2].fwd = 1'b1;
    settle;
    chk("adp2 forward", 8'h02, {6'h00, adp_pins[2]});
    go_idle;
    adapter_present = 2'h3;
    adapter_mode[1] = MODE_PLS_DIR;
    axis_cmd[2]     = '{active: 1'b1, pulse: 1'b1, fwd: 1'b1};
    settle;
    chk("adp2 pls dir", 8'h03, {6'h00, adp_pins[2]});
    chk("main pulse dir", 8'h44, main_out);
    axis_cmd[2].fwd = 1'b0;
    settle;
    chk("adp2 pls rev", 8'h02, {6'h00, adp_pins[2]});
    chk("main pulse rev", 8'h04, main_out);
    go_idle;
    adapter_present = 2'h1;
    axis_cmd[2]     = '{active: 1'b1, pulse: 1'b1, fwd: 1'b1};
    settle;
    chk("adp2 absent", 8'h00, {6'h00, adp_pins[2]});
    chk("main route", 8'h44, main_out);
    go_idle;
    $display("test adapter_formats done");
  endtask : test_adapter_formats

  task test_relay_unit;
    relay_main  = 1'b1;
    axis_cmd[1] = '{active: 1'b1, pulse: 1'b0, fwd: 1'b0};
    settle;
    chk("relay out", 8'h02, main_out);
    chk("relay led", 8'h02, main_led);
    go_idle;
    chk("relay off", 8'h00, main_out);
    $display("test relay_unit done");
  endtask : test_relay_unit

  task test_clear_remap;
    adapter_present = 2'h1;
    clear_cmd[0]    = '{req: 1'b1, remap: 1'b0, sel: 3'h0};
    settle;
    chk("clear blocked", 8'h01, {4'h0, clear_blocked});
    chk("clear default", 8'h00, main_out);
    clear_cmd[0] = '{req: 1'b1, remap: 1'b1, sel: 3'h6};
    settle;
    chk("clear moved", 8'h00, {4'h0, clear_blocked});
    chk("clear out", 8'h40, main_out);
    go_idle;
    $display("test clear_remap done");
  endtask : test_clear_remap

  // Main route, no adapter: 400-cycle spacing is legal, 4 is not
  task test_overspeed;
    axis_cmd[0] = '{active: 1'b1, pulse: 1'b1, fwd: 1'b1};
    step;
    axis_cmd[0].pulse = 1'b0;
    repeat (399) step;
    axis_cmd[0].pulse = 1'b1;
    settle;
    chk("overspeed legal", 8'h00, {4'h0, overspeed});
    axis_cmd[0].pulse = 1'b0;
    step;
    axis_cmd[0].pulse = 1'b1;
    settle;
    chk("overspeed fast", 8'h01, {4'h0, overspeed});
    // Flag is sticky; only a reset clears it
    rst = 1'b1;
    go_idle;
    chk("reset outputs", 8'h00, main_out);
    rst = 1'b0;
    settle;
    chk("overspeed reset", 8'h00, {4'h0, overspeed});
    $display("test overspeed done");
  endtask : test_overspeed

  // ****************************************************
  // Sequence and watchdog
  // ****************************************************
  initial begin
    ref_clk   = 1'b0;
    rst       = 1'b1;
    n_errors  = 0;
    cmp_count = 0;
    axis_cmd        = '0;
    clear_cmd       = '0;
    gp_out          = '0;
    relay_main      = 1'b0;
    adapter_present = '0;
    adapter_mode    = {MODE_FP_RP, MODE_FP_RP};
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    test_plain_outputs;
    test_adapter_formats;
    test_relay_unit;
    test_clear_remap;
    test_overspeed;
    chk("drive rate", 8'h00, {4'h0, too_fast});
    test_done;
  end

  // Whole run is well under 1000 cycles
  initial begin
    #50us;
    n_errors++;
    $display("watchdog expired");
    test_done;
  end
endmodule : pulse_output_axis_routing_tb
